// ### design/cip_defines.vh
`ifndef CIP_DEFINES_VH
`define CIP_DEFINES_VH
`define CIP_NSRC 16
`define CIP_VEC_RESET 16'hFFFE
`define CIP_VEC_TRAP 16'hFFFC
`define CIP_VEC_TOP 16'hFFFA
`define CIP_VEC_STEP 16'h0002
`define CIP_PRIO_NONE 5'h00
`define CIP_IDX_UPPER_STACKED 1'b0
`define CIP_ST_RUN 2'h0
`define CIP_ST_ENTER 2'h1
`define CIP_ST_SERVICE 2'h2
`endif

// ### design/cip_prioritizer.v
`timescale 1ns/10ps
`include "cip_defines.vh"
module cip_prioritizer (
  input wire MCLK,
  input wire ARST_N,
  // CPU core side
  input wire INSTR_DONE,
  input wire TRAP_EXEC,
  input wire RETURN_EXEC,
  input wire BREAK_MATCH,
  input wire GLOBAL_MASK,
  input wire [15:0] CUR_PC,
  input wire ENTRY_ACK,
  // Peripheral side
  input wire EXTERNAL_REQUEST_PIN_N,
  input wire EXTERNAL_REQUEST_MASK,
  input wire EXTERNAL_REQUEST_CLEAR,
  input wire PLL_LOCK,
  input wire PLL_CHANGE_ENABLE,
  input wire PLL_CHANGE_CLEAR,
  input wire [3:0] TIMER_CHANNEL_EVENT_FLAG,
  input wire [3:0] TIMER_CHANNEL_EVENT_ENABLE,
  input wire [1:0] TIMER_ROLLOVER_FLAG,
  input wire [1:0] TIMER_ROLLOVER_ENABLE,
  input wire SPI_RX_FULL_FLAG,
  input wire SPI_RX_FULL_ENABLE,
  input wire SPI_TX_EMPTY_FLAG,
  input wire SPI_TX_EMPTY_ENABLE,
  input wire SPI_SELECT_FAULT_FLAG,
  input wire SPI_SELECT_FAULT_DETECT,
  input wire SPI_RX_OVERRUN_FLAG,
  input wire SPI_FAULT_IRQ_ENABLE,
  input wire UART_TX_EMPTY_FLAG,
  input wire UART_TX_EMPTY_ENABLE,
  input wire UART_TX_DONE_FLAG,
  input wire UART_TX_DONE_ENABLE,
  input wire UART_RX_FULL_FLAG,
  input wire UART_RX_FULL_ENABLE,
  input wire UART_LINE_QUIET_FLAG,
  input wire UART_LINE_QUIET_ENABLE,
  input wire UART_RX_OVERRUN_FLAG,
  input wire UART_RX_OVERRUN_ENABLE,
  input wire UART_NOISE_FLAG,
  input wire UART_NOISE_ENABLE,
  input wire UART_STOP_BIT_BAD_FLAG,
  input wire UART_STOP_BIT_BAD_ENABLE,
  input wire UART_PARITY_BAD_FLAG,
  input wire UART_PARITY_BAD_ENABLE,
  input wire KEYPAD_REQUEST_FLAG,
  input wire KEYPAD_REQUEST_MASK,
  input wire ADC_DONE_FLAG,
  input wire ADC_DONE_ENABLE,
  input wire PERIODIC_TICK_FLAG,
  input wire PERIODIC_TICK_ENABLE,
  // Outputs
  output reg ENTRY_REQ,
  output reg [15:0] VECTOR,
  output reg [15:0] STACKED_PC,
  output reg [4:0] ENTRY_PRIO,
  output reg SET_GLOBAL_MASK,
  output reg PUSH_REGS,
  output reg POP_REGS,
  output reg STACK_IDX_UPPER,
  output reg FORCE_TRAP,
  output reg EXTERNAL_REQUEST_FLAG,
  output reg PLL_CHANGE_FLAG,
  output reg [`CIP_NSRC-1:0] SOURCE_PENDING_BITS
);

  // Lowest set index wins; index 0 maps to priority 1
  function [4:0] cip_pick;
    input [`CIP_NSRC-1:0] req;
    integer i;
    begin
      cip_pick = `CIP_PRIO_NONE;
      for (i = `CIP_NSRC - 1; i >= 0; i = i - 1) begin
        if (req[i]) begin
          cip_pick = i[4:0] + 5'h01;
        end
      end
    end
  endfunction

  // Vector pair address from priority, counting down from the top
  function [15:0] cip_vec;
    input [4:0] prio;
    begin
      cip_vec = `CIP_VEC_TOP - (({11'h000, prio} - 16'h0001) * `CIP_VEC_STEP);
    end
  endfunction

  reg ext_s1;
  reg ext_s2;
  reg lock_s1;
  reg lock_s2;
  reg lock_d;
  reg [1:0] state;
  reg [1:0] next_state;
  reg trap_pending;
  wire [`CIP_NSRC-1:0] grp_req;
  wire [4:0] win;
  wire spi_fault;
  wire uart_err;

  // Pins come from outside the clock domain
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ext_s1 <= 1'b1;
      ext_s2 <= 1'b1;
      lock_s1 <= 1'b0;
      lock_s2 <= 1'b0;
      lock_d <= 1'b0;
    end else begin
      ext_s1 <= EXTERNAL_REQUEST_PIN_N;
      ext_s2 <= ext_s1;
      lock_s1 <= PLL_LOCK;
      lock_s2 <= lock_s1;
      lock_d <= lock_s2;
    end
  end

  // Latched flags; set wins over clear so no event is lost
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      EXTERNAL_REQUEST_FLAG <= 1'b0;
      PLL_CHANGE_FLAG <= 1'b0;
    end else begin
      if (!ext_s2) begin
        EXTERNAL_REQUEST_FLAG <= 1'b1;
      end else if (EXTERNAL_REQUEST_CLEAR) begin
        EXTERNAL_REQUEST_FLAG <= 1'b0;
      end
      if (lock_s2 != lock_d) begin
        PLL_CHANGE_FLAG <= 1'b1;
      end else if (PLL_CHANGE_CLEAR) begin
        PLL_CHANGE_FLAG <= 1'b0;
      end
    end
  end

  // Peripheral flags are set inside their own units; only gated here
  assign spi_fault = (SPI_SELECT_FAULT_FLAG & SPI_SELECT_FAULT_DETECT)
    | SPI_RX_OVERRUN_FLAG;
  assign uart_err = (UART_RX_OVERRUN_FLAG & UART_RX_OVERRUN_ENABLE)
    | (UART_NOISE_FLAG & UART_NOISE_ENABLE)
    | (UART_STOP_BIT_BAD_FLAG & UART_STOP_BIT_BAD_ENABLE)
    | (UART_PARITY_BAD_FLAG & UART_PARITY_BAD_ENABLE);

  // Group requests, one bit per priority level
  assign grp_req[0] = EXTERNAL_REQUEST_FLAG & ~EXTERNAL_REQUEST_MASK;
  assign grp_req[1] = PLL_CHANGE_FLAG & PLL_CHANGE_ENABLE;
  assign grp_req[2] = TIMER_CHANNEL_EVENT_FLAG[0] & TIMER_CHANNEL_EVENT_ENABLE[0];
  assign grp_req[3] = TIMER_CHANNEL_EVENT_FLAG[1] & TIMER_CHANNEL_EVENT_ENABLE[1];
  assign grp_req[4] = TIMER_ROLLOVER_FLAG[0] & TIMER_ROLLOVER_ENABLE[0];
  assign grp_req[5] = TIMER_CHANNEL_EVENT_FLAG[2] & TIMER_CHANNEL_EVENT_ENABLE[2];
  assign grp_req[6] = TIMER_CHANNEL_EVENT_FLAG[3] & TIMER_CHANNEL_EVENT_ENABLE[3];
  assign grp_req[7] = TIMER_ROLLOVER_FLAG[1] & TIMER_ROLLOVER_ENABLE[1];
  assign grp_req[8] = (SPI_RX_FULL_FLAG & SPI_RX_FULL_ENABLE)
    | (spi_fault & SPI_FAULT_IRQ_ENABLE);
  assign grp_req[9] = SPI_TX_EMPTY_FLAG & SPI_TX_EMPTY_ENABLE;
  assign grp_req[10] = uart_err;
  assign grp_req[11] = (UART_RX_FULL_FLAG & UART_RX_FULL_ENABLE)
    | (UART_LINE_QUIET_FLAG & UART_LINE_QUIET_ENABLE);
  assign grp_req[12] = (UART_TX_EMPTY_FLAG & UART_TX_EMPTY_ENABLE)
    | (UART_TX_DONE_FLAG & UART_TX_DONE_ENABLE);
  assign grp_req[13] = KEYPAD_REQUEST_FLAG & ~KEYPAD_REQUEST_MASK;
  assign grp_req[14] = ADC_DONE_FLAG & ADC_DONE_ENABLE;
  assign grp_req[15] = PERIODIC_TICK_FLAG & PERIODIC_TICK_ENABLE;

  assign win = cip_pick(grp_req);

  // Status view, registered so outputs come from flops
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SOURCE_PENDING_BITS <= {`CIP_NSRC{1'b0}};
    end else begin
      SOURCE_PENDING_BITS <= grp_req;
    end
  end

  // Sequencer: run, enter (held until core acks), service
  always @* begin
    next_state = state;
    case (state)
      `CIP_ST_RUN: begin
        // Boundary only, never mid-instruction
        if (INSTR_DONE && (trap_pending || (!GLOBAL_MASK && win != `CIP_PRIO_NONE))) begin
          next_state = `CIP_ST_ENTER;
        end
      end
      `CIP_ST_ENTER: begin
        if (ENTRY_ACK) begin
          next_state = `CIP_ST_SERVICE;
        end
      end
      `CIP_ST_SERVICE: begin
        // Return reopens arbitration before the next program instruction
        if (RETURN_EXEC) begin
          next_state = `CIP_ST_RUN;
        end
      end
      default: begin
        next_state = `CIP_ST_RUN;
      end
    endcase
  end

  // Entry outputs latched once; no preemption while entering
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= `CIP_ST_RUN;
      trap_pending <= 1'b0;
      ENTRY_REQ <= 1'b0;
      VECTOR <= `CIP_VEC_RESET;
      STACKED_PC <= 16'h0000;
      ENTRY_PRIO <= `CIP_PRIO_NONE;
      SET_GLOBAL_MASK <= 1'b0;
      PUSH_REGS <= 1'b0;
      POP_REGS <= 1'b0;
      STACK_IDX_UPPER <= `CIP_IDX_UPPER_STACKED;
      FORCE_TRAP <= 1'b0;
    end else begin
      state <= next_state;
      FORCE_TRAP <= BREAK_MATCH;
      POP_REGS <= RETURN_EXEC && (state == `CIP_ST_SERVICE);
      STACK_IDX_UPPER <= `CIP_IDX_UPPER_STACKED;
      SET_GLOBAL_MASK <= 1'b0;
      PUSH_REGS <= 1'b0;
      if (TRAP_EXEC || BREAK_MATCH) begin
        trap_pending <= 1'b1;
      end else if (state == `CIP_ST_RUN && next_state == `CIP_ST_ENTER) begin
        trap_pending <= 1'b0;
      end
      if (state == `CIP_ST_RUN && next_state == `CIP_ST_ENTER) begin
        ENTRY_REQ <= 1'b1;
        SET_GLOBAL_MASK <= 1'b1;
        PUSH_REGS <= 1'b1;
        if (trap_pending) begin
          VECTOR <= `CIP_VEC_TRAP;
          STACKED_PC <= CUR_PC;
          ENTRY_PRIO <= `CIP_PRIO_NONE;
        end else begin
          VECTOR <= cip_vec(win);
          STACKED_PC <= CUR_PC - 16'h0001;
          ENTRY_PRIO <= win;
        end
      end else if (state == `CIP_ST_ENTER && ENTRY_ACK) begin
        ENTRY_REQ <= 1'b0;
      end
    end
  end

endmodule

// ### dv/cip_prio_sva.sv
`timescale 1ns/10ps
module cip_prio_sva (
  input logic MCLK,
  input logic ARST_N,
  input logic INSTR_DONE,
  input logic GLOBAL_MASK,
  input logic BREAK_MATCH,
  input logic ENTRY_ACK,
  input logic [15:0] CUR_PC,
  input logic ENTRY_REQ,
  input logic [15:0] VECTOR,
  input logic [15:0] STACKED_PC,
  input logic [4:0] ENTRY_PRIO,
  input logic SET_GLOBAL_MASK,
  input logic PUSH_REGS,
  input logic STACK_IDX_UPPER,
  input logic FORCE_TRAP
);
  // Single bus clock domain
  default clocking @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  boundary_entry_a: assert property ($rose(ENTRY_REQ) |-> $past(INSTR_DONE))
    else $error("entry away from a boundary");
  entry_pulses_a: assert property ((PUSH_REGS == $rose(ENTRY_REQ)) &&
    (SET_GLOBAL_MASK == PUSH_REGS)) else $error("entry pulses wrong");
  held_entry_a: assert property (ENTRY_REQ && !ENTRY_ACK |=> ENTRY_REQ && $stable(VECTOR))
    else $error("entry dropped or changed");
  mask_trap_a: assert property ($rose(ENTRY_REQ) && $past(GLOBAL_MASK) |-> ENTRY_PRIO == 5'h00)
    else $error("masked entry not a trap");
  vector_map_a: assert property (ENTRY_REQ |-> VECTOR == 16'hFFFC - {10'h000, ENTRY_PRIO, 1'b0})
    else $error("vector wrong");
  stacked_pc_a: assert property ($rose(ENTRY_REQ) |->
    STACKED_PC == $past(CUR_PC) - {15'h0000, ENTRY_PRIO != 5'h00}) else $error("stacked pc wrong");
  no_idx_stack_a: assert property (!STACK_IDX_UPPER)
    else $error("index upper stacked");
  break_trap_a: assert property (BREAK_MATCH |=> FORCE_TRAP)
    else $error("break did not force trap");
endmodule

// ### dv/cip_core_model.sv
`timescale 1ns/10ps
module cip_core_model (
  input logic MCLK,
  input logic ARST_N,
  input logic ENTRY_REQ,
  input logic slow,
  output logic ENTRY_ACK
);
  logic [2:0] wait_cnt;
  // Core takes the vector after its own fetch delay, one-cycle acknowledge
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N || ENTRY_ACK || !ENTRY_REQ) begin
      ENTRY_ACK <= 1'h0;
      wait_cnt <= 3'h0;
    end else if (wait_cnt >= (slow ? 3'h3 : 3'h0)) begin
      ENTRY_ACK <= 1'h1;
    end else begin
      wait_cnt <= wait_cnt + 3'h1;
    end
  end
endmodule

// ### dv/tb_cip_prioritizer.sv
`timescale 1ns/10ps
module tb_cip_prioritizer;
  logic MCLK=0, ARST_N=0, INSTR_DONE=0, TRAP_EXEC=0, RETURN_EXEC=0, BREAK_MATCH=0, slow=0;
  logic GLOBAL_MASK=0, EXTERNAL_REQUEST_PIN_N=1, EXTERNAL_REQUEST_MASK=0, EXTERNAL_REQUEST_CLEAR=0;
  logic PLL_LOCK=0, PLL_CHANGE_ENABLE=0, PLL_CHANGE_CLEAR=0;
  logic [15:0] CUR_PC=16'h1234;
  logic [3:0] TIMER_CHANNEL_EVENT_FLAG=0, TIMER_CHANNEL_EVENT_ENABLE=0;
  logic [1:0] TIMER_ROLLOVER_FLAG=0, TIMER_ROLLOVER_ENABLE=0;
  logic SPI_RX_FULL_FLAG=0, SPI_RX_FULL_ENABLE=0, SPI_TX_EMPTY_FLAG=0, SPI_TX_EMPTY_ENABLE=0;
  logic SPI_SELECT_FAULT_FLAG=0, SPI_SELECT_FAULT_DETECT=0, SPI_RX_OVERRUN_FLAG=0;
  logic SPI_FAULT_IRQ_ENABLE=0, UART_TX_EMPTY_FLAG=0, UART_TX_EMPTY_ENABLE=0, UART_TX_DONE_FLAG=0;
  logic UART_TX_DONE_ENABLE=0, UART_RX_FULL_FLAG=0, UART_RX_FULL_ENABLE=0, UART_LINE_QUIET_FLAG=0;
  logic UART_LINE_QUIET_ENABLE=0, UART_RX_OVERRUN_FLAG=0, UART_RX_OVERRUN_ENABLE=0;
  logic UART_NOISE_FLAG=0, UART_NOISE_ENABLE=0, UART_STOP_BIT_BAD_FLAG=0;
  logic UART_STOP_BIT_BAD_ENABLE=0, UART_PARITY_BAD_FLAG=0, UART_PARITY_BAD_ENABLE=0;
  logic KEYPAD_REQUEST_FLAG=0, KEYPAD_REQUEST_MASK=0, ADC_DONE_FLAG=0, ADC_DONE_ENABLE=0;
  logic PERIODIC_TICK_FLAG=0, PERIODIC_TICK_ENABLE=0;
  logic ENTRY_REQ, SET_GLOBAL_MASK, PUSH_REGS, POP_REGS, STACK_IDX_UPPER, FORCE_TRAP, ENTRY_ACK;
  logic EXTERNAL_REQUEST_FLAG, PLL_CHANGE_FLAG;
  logic [15:0] VECTOR, STACKED_PC, SOURCE_PENDING_BITS;
  logic [4:0] ENTRY_PRIO;
  int err_count = 0;
  int compares = 0;
  cip_prioritizer u_cip_prioritizer (.*);
  cip_core_model u_cip_core_model (.*);
  // Bus clock
  always #5 MCLK = ~MCLK;
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task conclude;
    if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One instruction ends; outputs read once the edge has settled
  task boundary;
    @(posedge MCLK) INSTR_DONE <= 1;
    @(posedge MCLK) INSTR_DONE <= 0;
    #1;
  endtask
  task take(input logic [4:0] p, input logic [15:0] pc);
    boundary;
    chk({ENTRY_REQ, PUSH_REGS, SET_GLOBAL_MASK, STACK_IDX_UPPER}, 4'hE);
    chk(ENTRY_PRIO, p);
    chk(VECTOR, 16'hFFFC - {10'h000, p, 1'b0});
    chk(STACKED_PC, pc);
  endtask
  // Core must have taken the entry before the handler can return
  task ret;
    for (int n = 0; n < 8 && ENTRY_REQ !== 1'b0; n++) @(posedge MCLK) #1;
    @(posedge MCLK) RETURN_EXEC <= 1;
    @(posedge MCLK) RETURN_EXEC <= 0;
    #1 chk(POP_REGS, 1);
  endtask
  initial begin
    repeat (6) @(posedge MCLK);
    ARST_N <= 1;
    #1 chk(VECTOR, 16'hFFFE);
    // Flag without its enable stays silent
    @(posedge MCLK) UART_PARITY_BAD_FLAG <= 1;
    boundary;
    boundary;
    chk(ENTRY_REQ, 0);
    chk(SOURCE_PENDING_BITS, 16'h0000);
    // Three groups at once, lowest number wins, others queue
    @(posedge MCLK) UART_PARITY_BAD_ENABLE <= 1;
    KEYPAD_REQUEST_FLAG <= 1;
    {PERIODIC_TICK_FLAG, PERIODIC_TICK_ENABLE} <= 2'h3;
    repeat (3) @(posedge MCLK);
    #1 chk(SOURCE_PENDING_BITS, 16'hA400);
    take(11, 16'h1233);
    @(posedge MCLK) EXTERNAL_REQUEST_PIN_N <= 0;
    repeat (4) @(posedge MCLK);
    #1 chk(EXTERNAL_REQUEST_FLAG, 1);
    boundary;
    chk(ENTRY_REQ, 0);
    @(posedge MCLK) EXTERNAL_REQUEST_PIN_N <= 1;
    UART_PARITY_BAD_FLAG <= 0;
    ret;
    take(1, 16'h1233);
    @(posedge MCLK) EXTERNAL_REQUEST_CLEAR <= 1;
    @(posedge MCLK) EXTERNAL_REQUEST_CLEAR <= 0;
    ret;
    take(14, 16'h1233);
    @(posedge MCLK) KEYPAD_REQUEST_FLAG <= 0;
    ret;
    take(16, 16'h1233);
    @(posedge MCLK) PERIODIC_TICK_FLAG <= 0;
    ret;
    // Each timer source alone, core fast and slow by turns
    @(posedge MCLK) {TIMER_ROLLOVER_ENABLE, TIMER_CHANNEL_EVENT_ENABLE} <= 6'h3F;
    for (int j = 0; j < 6; j++) begin
      @(posedge MCLK) {TIMER_ROLLOVER_FLAG, TIMER_CHANNEL_EVENT_FLAG} <= 6'h01 << j;
      slow <= j[0];
      take(5'((j < 4) ? j + 3 + j / 2 : 3 * j - 7), 16'h1233);
      @(posedge MCLK) {TIMER_ROLLOVER_FLAG, TIMER_CHANNEL_EVENT_FLAG} <= 6'h00;
      ret;
    end
    // Mask holds hardware requests back, the trap passes
    @(posedge MCLK) GLOBAL_MASK <= 1;
    {ADC_DONE_FLAG, ADC_DONE_ENABLE} <= 2'h3;
    boundary;
    boundary;
    chk(ENTRY_REQ, 0);
    @(posedge MCLK) TRAP_EXEC <= 1;
    @(posedge MCLK) TRAP_EXEC <= 0;
    take(0, 16'h1234);
    ret;
    @(posedge MCLK) GLOBAL_MASK <= 0;
    take(15, 16'h1233);
    @(posedge MCLK) ADC_DONE_FLAG <= 0;
    ret;
    @(posedge MCLK) BREAK_MATCH <= 1;
    @(posedge MCLK) BREAK_MATCH <= 0;
    #1 chk(FORCE_TRAP, 1);
    take(0, 16'h1234);
    ret;
    // Lock change raises the clock generator group
    @(posedge MCLK) {PLL_LOCK, PLL_CHANGE_ENABLE} <= 2'h3;
    repeat (5) @(posedge MCLK);
    #1 chk(PLL_CHANGE_FLAG, 1);
    take(2, 16'h1233);
    @(posedge MCLK) PLL_CHANGE_CLEAR <= 1;
    @(posedge MCLK) PLL_CHANGE_CLEAR <= 0;
    ret;
    // Serial groups: gated off first, then all five enabled together
    @(posedge MCLK) {SPI_SELECT_FAULT_FLAG, SPI_FAULT_IRQ_ENABLE, UART_NOISE_FLAG} <= 3'h7;
    {KEYPAD_REQUEST_FLAG, KEYPAD_REQUEST_MASK, UART_LINE_QUIET_FLAG} <= 3'h7;
    repeat (2) @(posedge MCLK);
    #1 chk(SOURCE_PENDING_BITS, 16'h0000);
    @(posedge MCLK) {SPI_SELECT_FAULT_DETECT, UART_NOISE_ENABLE, UART_LINE_QUIET_ENABLE} <= 3'h7;
    {SPI_TX_EMPTY_FLAG, SPI_TX_EMPTY_ENABLE, UART_TX_DONE_FLAG, UART_TX_DONE_ENABLE} <= 4'hF;
    repeat (2) @(posedge MCLK);
    #1 chk(SOURCE_PENDING_BITS, 16'h1F00);
    take(9, 16'h1233);
    @(posedge MCLK) {SPI_SELECT_FAULT_FLAG, SPI_TX_EMPTY_FLAG, UART_NOISE_FLAG} <= 3'h0;
    {UART_LINE_QUIET_FLAG, UART_TX_DONE_FLAG, KEYPAD_REQUEST_FLAG} <= 3'h0;
    ret;
    conclude;
  end
  // Hang guard, far beyond the expected run length
  initial begin
    repeat (3000) @(posedge MCLK);
    err_count++;
    conclude;
  end
endmodule
bind cip_prioritizer cip_prio_sva u_cip_prio_sva (.*);
